// file: hdl/sacc_defs.svh
// timing counts and field constants for the shared-clock converter control
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_RES_W        8
`define SACC_ADDR_W       4
`define SACC_SEL_SKIP     2
`define SACC_SHIFT_LAST   8
`define SACC_SAMPLE_EDGE  4
`define SACC_CONV_CYCLES  36
`define SACC_CNT_W        6
`define SACC_RESULT_RST   8'h00
`endif

// file: hdl/sacc_pkg.sv
// types for the shared-clock converter control
package sacc_pkg;
    typedef enum logic [3:0] {
        SACC_IDLE   = 4'b0001,
        SACC_QUAL   = 4'b0010,
        SACC_SHIFT  = 4'b0100,
        SACC_CONV   = 4'b1000
    } sacc_state_t;
endpackage

// file: hdl/sacc_buf2.sv
// two-entry valid/ready buffer for results
`timescale 1ns/1ps
module sacc_buf2 #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic [1:0]   cnt_q, cnt_d;
    logic         rp_q, rp_d, wp_q, wp_d;
    logic         push, pop;

    always_comb begin
        push      = in_valid && (cnt_q != 2'd2);
        pop       = out_ready && (cnt_q != 2'd0);
        mem_d     = mem_q;
        wp_d      = wp_q;
        rp_d      = rp_q;
        cnt_d     = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            cnt_q    <= 2'd0;
            rp_q     <= 1'b0;
            wp_q     <= 1'b0;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            rp_q  <= rp_d;
            wp_q  <= wp_d;
        end
    end

    assign in_ready  = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data  = mem_q[rp_q];
endmodule

// file: hdl/sacc_core.sv
// serial control of the converter with a shared conversion and shift clock
// What this block does
// - first two common-clock cycles after select low only qualify select
// - with select high, the common clock runs the conversion
// - select low counts after two rising then one falling clock edge, select high after one rising then one falling
// - no address bit shifts before a low select is recognised
// - two cycles after select falls shift no address bits
// - select held low keeps shifting further cycles until the conversion ends; the loaded address is kept
// - sampling begins at falling edge of fourth valid shift cycle
// - hold and conversion start at falling edge of eighth valid cycle
// - 4-bit address, msb first, taken on first four rising edges
// - previous result msb shown on recognition, rest on falling edges
// - conversion lasts 36 clock cycles; host keeps select high or clock low
// - select high: output hi-z, address and shift clock ignored
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_core (
    // system side
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    // link pins, common clock
    input  wire logic                    link_clk,
    input  wire logic                    sel_b,
    input  wire logic                    addr_in,
    output logic                         dout_o,
    output logic                         dout_oe,
    // converter core: controls on the system side, conv_res read on the link clock
    output logic                         smp_o,
    output logic                         hold_o,
    output logic [`SACC_ADDR_W-1:0]      chan_o,
    input  wire logic [`SACC_RES_W-1:0]  conv_res,
    // result stream out, system side
    output logic                         res_valid,
    input  wire logic                    res_ready,
    output logic [`SACC_RES_W-1:0]       res_data
);
    import sacc_pkg::*;

    // link domain: select qualified on common clock edges
    logic       sel_r1_q, sel_r2_q;
    logic       sel_fe_q;
    logic [1:0] rise_cnt_q, rise_cnt_d;
    logic       sel_ok_q, sel_ok_d;
    sacc_state_t st_q, st_d;
    logic [`SACC_CNT_W-1:0] cyc_q, cyc_d;
    logic [`SACC_ADDR_W-1:0] addr_q, addr_d;
    logic [`SACC_RES_W-1:0]  sh_q, sh_d;
    logic [`SACC_RES_W-1:0]  res_q, res_d;
    logic       samp_q, samp_d;
    logic       hold_q, hold_d;
    logic       done_tg_q, done_tg_d;
    logic [`SACC_ADDR_W-1:0] addr_rise_q;
    logic       rise_seen_q;

    // two-stage capture of select on rising edges of the common clock
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_r1_q    <= 1'b1;
            sel_r2_q    <= 1'b1;
            addr_rise_q <= '0;
            rise_seen_q <= 1'b0;
        end else begin
            sel_r1_q <= sel_b;
            sel_r2_q <= sel_r1_q;
            if (sel_ok_q && (st_q == SACC_SHIFT || st_q == SACC_CONV)) begin
                addr_rise_q <= {addr_rise_q[`SACC_ADDR_W-2:0], addr_in};
                rise_seen_q <= 1'b1;
            end else begin
                rise_seen_q <= 1'b0;
            end
        end
    end

    // falling-edge state: select recognition, shifting, conversion
    always_comb begin
        rise_cnt_d = rise_cnt_q;
        sel_ok_d   = sel_ok_q;
        st_d       = st_q;
        cyc_d      = cyc_q;
        addr_d     = addr_q;
        sh_d       = sh_q;
        res_d      = res_q;
        samp_d     = samp_q;
        hold_d     = hold_q;
        done_tg_d  = done_tg_q;
        case (st_q)
            SACC_IDLE, SACC_CONV: begin
                if (st_q == SACC_CONV) begin
                    // common clock drives conversion while select high
                    cyc_d = cyc_q + 1'b1;
                    if (cyc_q == `SACC_CONV_CYCLES - 1) begin
                        res_d     = conv_res;
                        hold_d    = 1'b0;
                        done_tg_d = ~done_tg_q;
                        st_d      = SACC_IDLE;
                    end
                end
                if (sel_r1_q) begin
                    // select released: later clocks are ignored
                    sel_ok_d = 1'b0;
                end else if (sel_ok_q) begin
                    // select never released: clocks keep shifting until the conversion ends
                    if (st_q == SACC_CONV && rise_seen_q) begin
                        sh_d = {sh_q[`SACC_RES_W-2:0], 1'b0};
                    end
                end else begin
                    // a new select low aborts a running conversion
                    rise_cnt_d = 2'd1;
                    st_d       = SACC_QUAL;
                    hold_d     = 1'b0;
                end
            end

            SACC_QUAL: begin
                // two rising edges then a falling one before select counts
                if (sel_r2_q) begin
                    st_d = SACC_IDLE;
                end else if (rise_cnt_q == `SACC_SEL_SKIP - 1) begin
                    sel_ok_d = 1'b1;
                    cyc_d    = '0;
                    sh_d     = res_q;
                    st_d     = SACC_SHIFT;
                end else begin
                    rise_cnt_d = rise_cnt_q + 1'b1;
                end
            end
            SACC_SHIFT: begin
                if (sel_r1_q) begin
                    sel_ok_d = 1'b0;
                    st_d     = SACC_IDLE;
                end else if (rise_seen_q) begin
                    cyc_d = cyc_q + 1'b1;
                    sh_d  = {sh_q[`SACC_RES_W-2:0], 1'b0};
                    if (cyc_q < `SACC_ADDR_W) begin
                        addr_d = addr_rise_q;
                    end
                    if (cyc_q == `SACC_SAMPLE_EDGE - 1) begin
                        samp_d = 1'b1;
                    end
                    if (cyc_q[2:0] == 3'(`SACC_SHIFT_LAST - 1)) begin
                        samp_d = 1'b0;
                        hold_d = 1'b1;
                        cyc_d  = '0;
                        st_d   = SACC_CONV;
                    end
                end
            end
            default: begin
                st_d = SACC_IDLE;
            end
        endcase
    end

    always_ff @(negedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_cnt_q <= 2'd0;
            sel_ok_q   <= 1'b0;
            st_q       <= SACC_IDLE;
            cyc_q      <= '0;
            addr_q     <= '0;
            sh_q       <= `SACC_RESULT_RST;
            res_q      <= `SACC_RESULT_RST;
            samp_q     <= 1'b0;
            hold_q     <= 1'b0;
            done_tg_q  <= 1'b0;
        end else begin
            rise_cnt_q <= rise_cnt_d;
            sel_ok_q   <= sel_ok_d;
            st_q       <= st_d;
            cyc_q      <= cyc_d;
            addr_q     <= addr_d;
            sh_q       <= sh_d;
            res_q      <= res_d;
            samp_q     <= samp_d;
            hold_q     <= hold_d;
            done_tg_q  <= done_tg_d;
        end
    end

    // serial output, driven only while select is recognised low
    always_ff @(negedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            dout_o  <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout_o  <= sh_d[`SACC_RES_W-1];
            dout_oe <= (st_d == SACC_SHIFT)
                       || (st_d == SACC_CONV && sel_ok_d);
        end
    end

    // system domain: three-stage capture of link state
    logic [2:0] tg_s_q, smp_s_q, hold_s_q;
    logic [2:0] ch_s0_q [`SACC_ADDR_W];
    logic       tg_seen_q, tg_seen_d;
    logic       smp_q, smp_d, hold_sq, hold_sd;
    logic [`SACC_ADDR_W-1:0] chan_q, chan_d;
    logic       bin_valid, bin_ready;
    logic       res_valid_q, res_valid_d;
    logic [`SACC_RES_W-1:0] res_data_q, res_data_d;
    logic [`SACC_RES_W-1:0] bout_data;
    logic       bout_valid;
    logic       bout_ready;
    logic [`SACC_ADDR_W-1:0] ch_now;
    logic       ch_agree;

    always_comb begin
        ch_agree = 1'b1;
        for (int i = 0; i < `SACC_ADDR_W; i++) begin
            ch_now[i] = ch_s0_q[i][2];
            if (ch_s0_q[i][1] != ch_s0_q[i][2]) begin
                ch_agree = 1'b0;
            end
        end
        tg_seen_d   = tg_seen_q;
        smp_d       = smp_q;
        hold_sd     = hold_sq;
        chan_d      = chan_q;
        bin_valid   = 1'b0;
        if (smp_s_q[1] == smp_s_q[2]) begin
            smp_d = smp_s_q[2];
        end
        if (hold_s_q[1] == hold_s_q[2]) begin
            hold_sd = hold_s_q[2];
        end
        if (ch_agree) begin
            chan_d = ch_now;
        end
        if (tg_s_q[1] == tg_s_q[2] && tg_s_q[2] != tg_seen_q) begin
            bin_valid = 1'b1;
            if (bin_ready) begin
                tg_seen_d = tg_s_q[2];
            end
        end
        bout_ready  = !res_valid_q || res_ready;
        res_valid_d = res_valid_q && !res_ready;
        res_data_d  = res_data_q;
        if (bout_valid && bout_ready) begin
            res_valid_d = 1'b1;
            res_data_d  = bout_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tg_s_q      <= '0;
            smp_s_q     <= '0;
            hold_s_q    <= '0;
            for (int i = 0; i < `SACC_ADDR_W; i++) begin
                ch_s0_q[i] <= '0;
            end
            tg_seen_q   <= 1'b0;
            smp_q       <= 1'b0;
            hold_sq     <= 1'b0;
            chan_q      <= '0;
            res_valid_q <= 1'b0;
            res_data_q  <= `SACC_RESULT_RST;
        end else begin
            tg_s_q   <= {tg_s_q[1:0], done_tg_q};
            smp_s_q  <= {smp_s_q[1:0], samp_q};
            hold_s_q <= {hold_s_q[1:0], hold_q};
            for (int i = 0; i < `SACC_ADDR_W; i++) begin
                ch_s0_q[i] <= {ch_s0_q[i][1:0], addr_q[i]};
            end
            tg_seen_q   <= tg_seen_d;
            smp_q       <= smp_d;
            hold_sq     <= hold_sd;
            chan_q      <= chan_d;
            res_valid_q <= res_valid_d;
            res_data_q  <= res_data_d;
        end
    end

    // result is stable in its link register long after the toggle settles
    sacc_buf2 #(
        .W(`SACC_RES_W)
    ) u_buf (
        .clk       (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (bin_valid),
        .in_ready  (bin_ready),
        .in_data   (res_q),
        .out_valid (bout_valid),
        .out_ready (bout_ready),
        .out_data  (bout_data)
    );

    assign smp_o     = smp_q;
    assign hold_o    = hold_sq;
    assign chan_o    = chan_q;
    assign res_valid = res_valid_q;
    assign res_data  = res_data_q;
endmodule

// file: verification/sacc_core_props.sv
// assertions on the converter control pins and result stream
`timescale 1ns/1ps
module sacc_core_props (
    // clocks and reset
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       link_clk,
    // link pins
    input wire logic       sel_b,
    input wire logic       dout_oe,
    // system side
    input wire logic       smp_o,
    input wire logic       hold_o,
    input wire logic [3:0] chan_o,
    input wire logic       res_valid,
    input wire logic       res_ready,
    input wire logic [7:0] res_data
);
    logic [6:0] hcnt_q;
    logic [6:0] hcnt_d;
    always_comb hcnt_d = hold_o ? hcnt_q + 7'h01 : 7'h00;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) hcnt_q <= 7'h00;
        else hcnt_q <= hcnt_d;
    end
    a_qual_two: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        $past(sel_b, 2) && $past(sel_b) && !sel_b
        |-> !dout_oe ##1 !dout_oe ##1 (dout_oe || sel_b))
        else $error("select recognised at wrong cycle");
    a_oe_off: assert property (
        @(posedge link_clk) disable iff (!rst_b) sel_b [*3] |-> !dout_oe)
        else $error("output driven while deselected");
    a_oe_held: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        dout_oe && !sel_b ##1 !sel_b |-> dout_oe)
        else $error("shifting stopped with select low");
    a_chan_quiet: assert property (
        @(posedge link_clk) disable iff (!rst_b)
        sel_b [*3] |-> $stable(chan_o))
        else $error("address changed while deselected");
    a_valid_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        res_valid && !res_ready |=> res_valid && $stable(res_data))
        else $error("result dropped before taken");
    a_smp_first: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(hold_o) |-> $past(smp_o, 2))
        else $error("hold without sampling");
    a_smp_ends: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(hold_o) |-> ##[0:1] !smp_o)
        else $error("sampling continues in hold");
    a_conv_len: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(hold_o) && sel_b |-> hcnt_q >= 7'h28 && hcnt_q <= 7'h2f)
        else $error("conversion length wrong");
    a_res_soon: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(hold_o) && sel_b |-> ##[1:8] res_valid)
        else $error("result not offered");
    c_abort: cover property (@(posedge sys_clk) $fell(hold_o) && !sel_b);
    c_stall: cover property (@(posedge sys_clk)
        res_valid && !res_ready ##1 res_valid && !res_ready);
    c_take: cover property (@(posedge sys_clk) res_valid && res_ready);
endmodule

// file: verification/sacc_host.sv
// host model driving the shared clock, select and address pins
`timescale 1ns/1ps
module sacc_host (
    // link pins
    output logic             link_clk,
    output logic             sel_b,
    output logic             addr_in,
    input  wire logic        dout_o,
    // bench control
    input  wire logic        go,
    input  wire logic [3:0]  addr,
    input  wire logic [1:0]  extra,
    input  wire logic        strobe,
    output logic [7:0]       got,
    output logic             done
);
    int hi = 15;
    bit sh = 0;
    initial begin
        link_clk = 0;
        forever begin
            #15 link_clk = 1;
            #(hi) link_clk = 0;
        end
    end
    always @(negedge link_clk) if (!sh) addr_in <= ~addr_in;
    initial begin
        sel_b = 1;
        addr_in = 0;
        done = 1;
        got = 0;
        forever begin
            @(posedge go);
            done = 0;
            @(negedge link_clk);
            sh = 1;
            sel_b <= 0;
            repeat (2) @(negedge link_clk);
            for (int k = 0; k < 8 + extra; k++) begin
                addr_in <= (k < 4) ? addr[3-k] : ~addr_in;
                if (k == 7 && strobe) hi = 315;
                @(posedge link_clk);
                if (k < 8) got[7-k] = dout_o;
                @(negedge link_clk);
                hi = 15;
            end
            sel_b <= 1;
            sh = 0;
            repeat (4) @(negedge link_clk);
            done = 1;
        end
    end
endmodule

// file: verification/sacc_core_test.sv
// self-checking bench for the shared-clock converter control
`timescale 1ns/1ps
module sacc_core_test;
    logic       sys_clk;
    logic       rst_b;
    logic       link_clk;
    logic       sel_b;
    logic       addr_in;
    logic       dout_o;
    logic       dout_oe;
    logic       smp_o;
    logic       hold_o;
    logic [3:0] chan_o;
    logic [7:0] conv_res;
    logic       res_valid;
    logic       res_ready;
    logic [7:0] res_data;
    logic       go;
    logic [3:0] addr;
    logic [1:0] extra;
    logic       strobe;
    logic [7:0] got;
    logic       done;
    bit         stall;
    int         fails = 0;
    int         total_checks = 0;
    int         last = 0;
    int         exp[$];
    sacc_core u_sacc_core (.sys_clk, .rst_b, .link_clk, .sel_b, .addr_in,
        .dout_o, .dout_oe, .smp_o, .hold_o, .chan_o, .conv_res,
        .res_valid, .res_ready, .res_data);
    sacc_host u_host (.link_clk, .sel_b, .addr_in, .dout_o, .go, .addr,
        .extra, .strobe, .got, .done);
    task automatic final_report;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string n, int e, logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %0h got %h", n, e, s);
        end
    endtask
    task automatic frame(bit w, bit s, bit [1:0] x);
        int n;
        @(negedge sys_clk);
        addr = 4'($urandom);
        conv_res = 8'($urandom);
        strobe = s;
        extra = x;
        if (w) exp.push_back(conv_res);
        go = 1;
        @(negedge sys_clk);
        go = 0;
        for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge sys_clk);
        if (n >= 400) begin
            fails++;
            $display("[ERR] wait exp done got timeout");
            final_report;
        end
        chk("readout", last, got);
        if (x == 0) chk("chan", addr, {4'h0, chan_o});
        if (w) begin
            repeat (40) @(negedge link_clk);
            chk("hold", 0, {7'h00, hold_o});
            last = conv_res;
        end
    endtask
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) res_ready <= stall ? 1'b0 : 1'($urandom);
    always @(posedge sys_clk) if (rst_b && res_valid && res_ready) begin
        chk("stream", exp.size() ? exp.pop_front() : -1, res_data);
    end
    always @(posedge link_clk) if (strobe && !sel_b) begin
        #20;
        if (link_clk) begin
            #180;
            chk("smp", 1, {7'h00, smp_o});
            chk("hold", 0, {7'h00, hold_o});
            @(negedge link_clk);
            #200;
            chk("hold", 1, {7'h00, hold_o});
        end
    end
    initial begin
        rst_b = 0;
        go = 0;
        addr = 4'h0;
        extra = 2'h0;
        strobe = 0;
        conv_res = 8'h00;
        stall = 0;
        res_ready = 0;
        void'($urandom(32'h173ec959));
        repeat (10) @(negedge sys_clk);
        rst_b = 1;
        for (int i = 0; i < 6; i++) frame(1, 0, 0);
        $display("test basic done");
        frame(0, 0, 0);
        frame(1, 0, 0);
        $display("test abort done");
        frame(1, 1, 0);
        $display("test strobe done");
        frame(0, 0, 2);
        frame(1, 0, 0);
        $display("test overrun done");
        stall = 1;
        frame(1, 0, 0);
        frame(1, 0, 0);
        stall = 0;
        repeat (20) @(negedge sys_clk);
        chk("drained", 0, 8'(exp.size()));
        $display("test stall done");
        final_report;
    end
endmodule
bind sacc_core sacc_core_props u_sacc_core_props (.sys_clk, .rst_b,
    .link_clk, .sel_b, .dout_oe, .smp_o, .hold_o, .chan_o, .res_valid,
    .res_ready, .res_data);
